// ---- sac_comp_model.sv ----
// sac_comp_model: ideal comparator answering the trial code.
// assumes the input level is held for the whole conversion.
`timescale 1ns/1ps
module sac_comp_model
(
    input  wire logic [11:0] dac_code_i,
    input  wire logic [11:0] vin_i,
    output logic             comp_o
);
    // trial bit kept while the trial does not exceed the input
    assign comp_o = (dac_code_i <= vin_i);
endmodule : sac_comp_model

// ---- sac_conv_ctrl.sv ----
// sac_conv_ctrl: sequencing, output enables and serial shifter of a 12-bit SAR converter.
// assumes control pins are synchronous to CORE_CLK_I; the analog comparator
// result arrives on COMP_I, sampled while the trial word stands on DAC_CODE_O.
`timescale 1ns/1ps

// Contract
// - twelve result bits decided one per step against the capacitive dac
// - enabled and selected, falling read_not_convert starts a conversion
// - rising chip_enable or falling chip_select_n also start, read_not_convert low
// - a start during a running conversion abandons it and restarts
// - conversion_status high and parallel outputs off while converting
// - one conversion takes 38 internal conversion clock cycles
// - sequencing runs from a free internal 4 MHz clock, no clock pin
// - result placed first, conversion_status falls about 1.5 clocks later
// - outputs driven only when enabled, selected and reading; full word byte_select low
// - byte_select high: low nibble on top lines, zeros below, low lines unchanged
// - serial output msb first, advancing on each falling serial shift clock
// - serial shift clock edges ignored unless the serial output is enabled
module sac_conv_ctrl
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        CHIP_ENABLE_I,
    input  wire logic        CHIP_SELECT_N_I,
    input  wire logic        READ_NOT_CONVERT_I,
    input  wire logic        BYTE_SELECT_I,
    input  wire logic        SERIAL_SHIFT_CLOCK_I,
    input  wire logic        COMP_I,
    output logic [11:0]      DAC_CODE_O,
    output logic             CONVERSION_STATUS_O,
    output logic [11:0]      PARALLEL_DATA_OUT_O,
    output logic [11:0]      PARALLEL_DATA_OE_O,
    output logic             SERIAL_DATA_OUT_O,
    output logic             SERIAL_DATA_OE_O
);

    logic                    rst_meta;
    logic                    rst_n;
    logic                    ce_d;
    logic                    cs_n_d;
    logic                    rnc_d;
    logic                    sclk_d;
    logic [2:0]              div_cnt;
    logic [2:0]              next_div_cnt;
    logic                    half_tick;
    logic                    conv_phase;
    logic                    next_conv_phase;
    logic                    start;
    logic                    read_en;

    sac_pkg::sac_state_t     state;
    sac_pkg::sac_state_t     next_state;
    logic [5:0]              tick;
    logic [5:0]              next_tick;
    logic [11:0]             sar;
    logic [11:0]             next_sar;
    logic [11:0]             trial;
    logic [11:0]             next_trial;
    logic [11:0]             dac;
    logic [11:0]             next_dac;
    logic [11:0]             result;
    logic [11:0]             next_result;
    logic [1:0]              lag;
    logic [1:0]              next_lag;
    logic                    status;
    logic                    next_status;
    logic [11:0]             shreg;
    logic [11:0]             next_shreg;
    logic [11:0]             pdata;
    logic [11:0]             next_pdata;
    logic                    oe;
    logic                    next_oe;

    // enabled and selected: the gate shared by reads and read_not_convert starts
    function automatic logic sac_selected
    (
        input logic ce,
        input logic cs_n
    );
        return ce && !cs_n;
    endfunction : sac_selected

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // free-running internal conversion clock, 8 MHz half ticks
    always_comb
    begin
        next_div_cnt    = div_cnt + 3'h1;
        next_conv_phase = conv_phase;
        if (half_tick)
        begin
            next_div_cnt    = 3'h0;
            next_conv_phase = ~conv_phase;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt    <= 3'h0;
            conv_phase <= 1'b0;
        end
        else
        begin
            div_cnt    <= next_div_cnt;
            conv_phase <= next_conv_phase;
        end
    end

    // three bits: the count runs 0..4 for a five-cycle half period
    assign half_tick = (div_cnt == 3'(sac_pkg::CONV_HALF_CYC - 1));

    // previous pin levels for edge detection
    // reset to levels that form no start edge, so release never fakes a conversion
    always_ff @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ce_d   <= 1'b1;
            cs_n_d <= 1'b0;
            rnc_d  <= 1'b0;
            sclk_d <= 1'b0;
        end
        else
        begin
            ce_d   <= CHIP_ENABLE_I;
            cs_n_d <= CHIP_SELECT_N_I;
            rnc_d  <= READ_NOT_CONVERT_I;
            sclk_d <= SERIAL_SHIFT_CLOCK_I;
        end
    end

    always_comb
    begin
        start = 1'b0;
        if (sac_selected(CHIP_ENABLE_I, CHIP_SELECT_N_I) && rnc_d && !READ_NOT_CONVERT_I)
            start = 1'b1;
        else if (!ce_d && CHIP_ENABLE_I && !CHIP_SELECT_N_I && !READ_NOT_CONVERT_I)
            start = 1'b1;
        // rising chip_select_n only deselects; it never starts a conversion
        else if (CHIP_ENABLE_I && !cs_n_d && CHIP_SELECT_N_I)
            start = 1'b0;
        else if (CHIP_ENABLE_I && cs_n_d && !CHIP_SELECT_N_I && !READ_NOT_CONVERT_I)
            start = 1'b1;
    end

    assign read_en = sac_selected(CHIP_ENABLE_I, CHIP_SELECT_N_I) && READ_NOT_CONVERT_I;

    // conversion sequencer: 12 decisions inside a 38-tick frame
    always_comb
    begin
        next_state  = state;
        next_tick   = tick;
        next_sar    = sar;
        next_trial  = trial;
        next_result = result;
        next_lag    = lag;
        next_status = status;
        case (state)
            sac_pkg::SAC_IDLE:
            begin
                next_status = 1'b0;
            end
            sac_pkg::SAC_CONV:
            begin
                if (half_tick && conv_phase)
                begin
                    next_tick = tick + 6'h01;
                    if (tick >= 6'(sac_pkg::SETTLE_TICKS)
                        && tick < 6'(sac_pkg::SETTLE_TICKS + sac_pkg::RESULT_W))
                    begin
                        // keep or drop the trial bit, then try the next lower one
                        next_sar   = COMP_I ? (sar | trial) : sar;
                        next_trial = trial >> 1;
                    end
                    if (tick == 6'(sac_pkg::CONV_TICKS - 1))
                    begin
                        next_result = sar;
                        next_lag    = 2'h0;
                        next_state  = sac_pkg::SAC_FINISH;
                    end
                end
            end
            sac_pkg::SAC_FINISH:
            begin
                // data is already driven; status drops after three half ticks
                if (half_tick)
                begin
                    next_lag = lag + 2'h1;
                    if (lag == 2'(sac_pkg::STS_LAG_HALVES - 1))
                    begin
                        next_status = 1'b0;
                        next_state  = sac_pkg::SAC_IDLE;
                    end
                end
            end
            default:
            begin
                next_state = sac_pkg::SAC_IDLE;
            end
        endcase
        if (start)
        begin
            // restart wins over anything in flight
            next_state  = sac_pkg::SAC_CONV;
            next_tick   = sac_pkg::TICK_RESET;
            next_sar    = sac_pkg::RESULT_RESET;
            next_trial  = sac_pkg::SAR_MSB;
            next_status = 1'b1;
        end
        // registered copy keeps the code a flop output, still equal to sar | trial
        next_dac = next_sar | next_trial;
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state  <= sac_pkg::SAC_IDLE;
            tick   <= sac_pkg::TICK_RESET;
            sar    <= sac_pkg::RESULT_RESET;
            trial  <= sac_pkg::SAR_MSB;
            dac    <= sac_pkg::SAR_MSB;
            result <= sac_pkg::RESULT_RESET;
            lag    <= 2'h0;
            status <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            tick   <= next_tick;
            sar    <= next_sar;
            trial  <= next_trial;
            dac    <= next_dac;
            result <= next_result;
            lag    <= next_lag;
            status <= next_status;
        end
    end

    // output stage: parallel word, byte view and serial shifter
    always_comb
    begin
        next_oe    = 1'b0;
        next_pdata = result;
        next_shreg = shreg;
        // a start in this cycle keeps the outputs off, so no stale word is read
        if (read_en && state != sac_pkg::SAC_CONV && !start)
            next_oe = 1'b1;
        if (BYTE_SELECT_I)
            next_pdata = {result[3:0], sac_pkg::NIBBLE_ZERO, result[3:0]};
        if (state == sac_pkg::SAC_CONV && next_state == sac_pkg::SAC_FINISH)
            next_shreg = sar;
        else if (oe && sclk_d && !SERIAL_SHIFT_CLOCK_I)
            next_shreg = {shreg[10:0], 1'b0};
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shreg <= sac_pkg::RESULT_RESET;
            pdata <= sac_pkg::RESULT_RESET;
            oe    <= 1'b0;
        end
        else
        begin
            shreg <= next_shreg;
            pdata <= next_pdata;
            oe    <= next_oe;
        end
    end

    assign DAC_CODE_O          = dac;
    assign CONVERSION_STATUS_O = status;
    assign PARALLEL_DATA_OUT_O = pdata;
    assign PARALLEL_DATA_OE_O  = {12{oe}};
    assign SERIAL_DATA_OUT_O   = shreg[11];
    assign SERIAL_DATA_OE_O    = oe;

endmodule : sac_conv_ctrl

// ---- sac_conv_ctrl_assertions.sv ----
// sac_chk: port checker for sac_conv_ctrl, bound below.
// assumes control pins change just after core clock edges.
`timescale 1ns/1ps
module sac_chk
(
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        CHIP_ENABLE_I,
    input wire logic        CHIP_SELECT_N_I,
    input wire logic        READ_NOT_CONVERT_I,
    input wire logic        BYTE_SELECT_I,
    input wire logic        CONVERSION_STATUS_O,
    input wire logic [11:0] PARALLEL_DATA_OUT_O,
    input wire logic [11:0] PARALLEL_DATA_OE_O,
    input wire logic        SERIAL_DATA_OE_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic       rd;
    logic [9:0] cnt;
    assign rd = CHIP_ENABLE_I && !CHIP_SELECT_N_I && READ_NOT_CONVERT_I;
    // only read_not_convert restarts are counted; the bench restarts no other way
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
        if (!RESET_N_I)
            cnt <= 10'h000;
        else if (!CONVERSION_STATUS_O || (rd == 1'b0 && $fell(READ_NOT_CONVERT_I)))
            cnt <= 10'h000;
        else
            cnt <= cnt + 10'h001;
    a_read_gates_oe: assert property (PARALLEL_DATA_OE_O[0] |-> $past(rd) || $past(rd, 2))
        else $error("outputs driven without read enable");
    a_rnc_start: assert property (
        CHIP_ENABLE_I && !CHIP_SELECT_N_I && $fell(READ_NOT_CONVERT_I)
        |=> (CONVERSION_STATUS_O && !PARALLEL_DATA_OE_O[0])[*3])
        else $error("falling read_not_convert did not start");
    a_ce_start: assert property (
        $rose(CHIP_ENABLE_I) && !CHIP_SELECT_N_I && !READ_NOT_CONVERT_I |=> CONVERSION_STATUS_O)
        else $error("rising chip_enable did not start");
    a_cs_start: assert property (
        CHIP_ENABLE_I && $fell(CHIP_SELECT_N_I) && !READ_NOT_CONVERT_I |=> CONVERSION_STATUS_O)
        else $error("falling chip_select_n did not start");
    a_len_max: assert property (cnt < 10'h1a4)
        else $error("conversion runs too long");
    a_len_min: assert property ($fell(CONVERSION_STATUS_O) |-> $past(cnt) >= 10'h172)
        else $error("conversion ended too early");
    a_oe_uniform: assert property (
        (PARALLEL_DATA_OE_O == 12'h000 || PARALLEL_DATA_OE_O == 12'hfff)
        && SERIAL_DATA_OE_O == PARALLEL_DATA_OE_O[0])
        else $error("output enables disagree");
    a_byte_view: assert property (
        PARALLEL_DATA_OE_O[0] && $past(PARALLEL_DATA_OE_O[0])
        && BYTE_SELECT_I && $past(BYTE_SELECT_I) && $past(BYTE_SELECT_I, 2)
        |-> PARALLEL_DATA_OUT_O[7:4] == 4'h0
        && PARALLEL_DATA_OUT_O[11:8] == PARALLEL_DATA_OUT_O[3:0])
        else $error("second byte view wrong");
    a_data_first: assert property (
        $fell(CONVERSION_STATUS_O) && $past(rd, 3) && $past(rd, 2) && $past(rd)
        |-> $past(PARALLEL_DATA_OE_O[0]))
        else $error("status fell before data was driven");
    a_result_hold: assert property (
        PARALLEL_DATA_OE_O[0] && $past(PARALLEL_DATA_OE_O[0]) && $stable(BYTE_SELECT_I)
        && !$past(BYTE_SELECT_I) && !$past(BYTE_SELECT_I, 2) |-> $stable(PARALLEL_DATA_OUT_O))
        else $error("held result changed");
    c_done: cover property ($fell(CONVERSION_STATUS_O));
    c_ce_start: cover property ($rose(CHIP_ENABLE_I) && !CHIP_SELECT_N_I && !READ_NOT_CONVERT_I);
    c_byte: cover property (PARALLEL_DATA_OE_O[0] && BYTE_SELECT_I);
endmodule : sac_chk

bind sac_conv_ctrl sac_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
    .CHIP_ENABLE_I(CHIP_ENABLE_I), .CHIP_SELECT_N_I(CHIP_SELECT_N_I),
    .READ_NOT_CONVERT_I(READ_NOT_CONVERT_I), .BYTE_SELECT_I(BYTE_SELECT_I),
    .CONVERSION_STATUS_O(CONVERSION_STATUS_O), .PARALLEL_DATA_OUT_O(PARALLEL_DATA_OUT_O),
    .PARALLEL_DATA_OE_O(PARALLEL_DATA_OE_O), .SERIAL_DATA_OE_O(SERIAL_DATA_OE_O));

// ---- sac_pkg.sv ----
// sac_pkg: constants for the converter control block.
// assumes a single 40 MHz core clock; no registers reachable by software.
package sac_pkg;
    localparam int unsigned RESULT_W        = 12;
    localparam int unsigned CORE_CLK_HZ     = 40_000_000;
    localparam int unsigned CONV_CLK_HZ     = 4_000_000;
    // internal conversion clock half period, in core cycles
    localparam int unsigned CONV_HALF_CYC   = CORE_CLK_HZ / CONV_CLK_HZ / 2;
    localparam int unsigned CONV_TICKS      = 38;
    // status falls about 1.5 conversion clocks after data is placed
    localparam int unsigned STS_LAG_HALVES  = 3;
    localparam int unsigned SETTLE_TICKS    = 2;
    localparam logic [5:0]  TICK_RESET      = 6'h00;
    localparam logic [11:0] RESULT_RESET    = 12'h000;
    localparam logic [11:0] SAR_MSB         = 12'h800;
    localparam logic [3:0]  NIBBLE_ZERO     = 4'h0;

    typedef enum logic [2:0]
    {
        SAC_IDLE   = 3'b001,
        SAC_CONV   = 3'b010,
        SAC_FINISH = 3'b100
    } sac_state_t;
endpackage : sac_pkg

// ---- test_sar_adc_conversion_control.sv ----
// test_sar_adc_conversion_control: self-checking bench for sac_conv_ctrl.
// assumes the comparator model closes the conversion loop.
`timescale 1ns/1ps
module test_sar_adc_conversion_control;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cs_n = 1'b0, read_not_convert = 1'b1;
    logic        bs = 1'b0, sclk = 1'b0, comp, sts, serial_data_out, soe, oe_q = 1'b0;
    logic [11:0] vin = 12'h000, dac, pdo, poe, r;
    logic [31:0] seed = 32'd60747;
    logic [11:0] exp_q[$];
    int          fails = 0, num_checks = 0, cyc = 0, k;
    always #12.5 clk = ~clk;
    sac_conv_ctrl DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CHIP_ENABLE_I(ce),
        .CHIP_SELECT_N_I(cs_n), .READ_NOT_CONVERT_I(read_not_convert), .BYTE_SELECT_I(bs),
        .SERIAL_SHIFT_CLOCK_I(sclk), .COMP_I(comp), .DAC_CODE_O(dac),
        .CONVERSION_STATUS_O(sts), .PARALLEL_DATA_OUT_O(pdo), .PARALLEL_DATA_OE_O(poe),
        .SERIAL_DATA_OUT_O(serial_data_out), .SERIAL_DATA_OE_O(soe));
    sac_comp_model u_comp (.dac_code_i(dac), .vin_i(vin), .comp_o(comp));
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        num_checks++;
        if (seen !== want)
        begin
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
            fails++;
        end
    endtask : check
    task automatic test_done;
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic pick;
        seed = xorshift(seed);
        r = seed[11:0];
        vin <= r;
    endtask : pick
    task automatic wait_idle;
        for (int n = 0; n < 600 && sts !== 1'b0; n++)
            @(posedge clk);
        if (sts !== 1'b0)
            fails++;
    endtask : wait_idle
    task automatic conv;
        pick;
        read_not_convert <= 1'b0;
        exp_q.push_back(r);
        tick(2);
        read_not_convert <= 1'b1;
        tick(50);
        check(poe, 12'h000);
        wait_idle;
        tick(3);
    endtask : conv
    task automatic closed(input bit by_cs);
        if (by_cs)
            cs_n <= 1'b1;
        else
            ce <= 1'b0;
        tick(2);
        read_not_convert <= 1'b0;
        pick;
        tick(2);
        if (by_cs)
            cs_n <= 1'b0;
        else
            ce <= 1'b1;
        exp_q.push_back(r);
        tick(3);
        wait_idle;
        read_not_convert <= 1'b1;
        tick(5);
    endtask : closed
    // results are compared when the outputs turn on
    always @(negedge clk)
    begin
        if (oe_q === 1'b0 && poe[0] === 1'b1)
        begin
            if (exp_q.size() == 0)
                fails++;
            else
                check(pdo, exp_q.pop_front());
        end
        oe_q = poe[0];
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            fails++;
            test_done;
        end
    end
    initial
    begin
        // a read before any conversion shows the reset result
        exp_q.push_back(sac_pkg::RESULT_RESET);
        tick(20);
        rst_n <= 1'b1;
        tick(5);
        repeat (3) conv();
        read_not_convert <= 1'b0;
        tick(2);
        read_not_convert <= 1'b1;
        tick(100);
        conv();
        closed(1'b0);
        closed(1'b1);
        bs <= 1'b1;
        tick(3);
        check(pdo, {r[3:0], 4'h0, r[3:0]});
        bs <= 1'b0;
        cs_n <= 1'b1;
        tick(3);
        check(poe, 12'h000);
        repeat (4)
        begin
            sclk <= 1'b1;
            tick(2);
            sclk <= 1'b0;
            tick(2);
        end
        cs_n <= 1'b0;
        exp_q.push_back(r);
        tick(3);
        for (k = 0; k < 12; k++)
        begin
            check({11'h000, serial_data_out}, {11'h000, r[11 - k]});
            sclk <= 1'b1;
            tick(3);
            sclk <= 1'b0;
            tick(3);
        end
        check(12'(exp_q.size()), 12'h000);
        test_done;
    end
endmodule : test_sar_adc_conversion_control
